// ### design/tdct_map.svh
// Purpose: register offsets, field positions, reset values and timing counts of the timer block
// Assumes: AHB-Lite byte addresses, one aligned 32-bit word per register
// Notes: definitions only
`ifndef TDCT_MAP_SVH
`define TDCT_MAP_SVH

// ==========================================================================
// Register offsets, timer n at base n*0x20
`define TDCT_TMR_STRIDE 8'h20
`define TDCT_OFF_LOAD 8'h00
`define TDCT_OFF_VALUE 8'h04
`define TDCT_OFF_CTRL 8'h08
`define TDCT_OFF_CLEAR 8'h0C
`define TDCT_OFF_SYSCTL 8'h60
`define TDCT_OFF_IRQ_STAT 8'h64
`define TDCT_OFF_IRQ_MASK 8'h68

// ==========================================================================
// Control register fields
`define TDCT_CTRL_ENABLE 7
`define TDCT_CTRL_MODE 6

// ==========================================================================
// System control fields: timer n clock select at 2n, mode at 2n+1
`define TDCT_SYS_CLKSEL0 0
`define TDCT_SYS_MODE0 1
`define TDCT_SYS_CLKSEL1 2
`define TDCT_SYS_MODE1 3

// ==========================================================================
// Reset values
`define TDCT_RST_COUNT 16'h0000
`define TDCT_RST_WRAP 16'hFFFF

// ==========================================================================
// Timing: ref_clk 25 MHz; tick rates in Hz, divisors rounded down
`define TDCT_REF_HZ 25000000
`define TDCT_FAST_HZ 508000
`define TDCT_SLOW_HZ 2000
`define TDCT_T3_HZ 7372800
`define TDCT_DIV_FAST (`TDCT_REF_HZ / `TDCT_FAST_HZ)
`define TDCT_DIV_SLOW (`TDCT_REF_HZ / `TDCT_SLOW_HZ)
`define TDCT_DIV_T3 (`TDCT_REF_HZ / `TDCT_T3_HZ)

`endif

// ### design/tdct_pkg.sv
// Purpose: shared types of the timer block
// Assumes: constants in tdct_map.svh
// Notes: none
package tdct_pkg;

  // ==========================================================================
  // AHB-Lite slave request
  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic hready;
  } tdct_ahb_req_t;

  // ==========================================================================
  // Bus access decoded in the data phase
  typedef enum logic [2:0] {
    TDCT_BUS_IDLE = 3'h1,
    TDCT_BUS_ADDR = 3'h2,
    TDCT_BUS_DATA = 3'h4
  } tdct_bus_state_t;

endpackage

// ### design/tdct_timers.sv
// Purpose: three 16-bit down-counting timers behind an AHB-Lite slave
// Assumes: ref_clk 25 MHz; single-word transfers; response always OKAY
// Notes: zero wait states; tick sources derived from ref_clk
`timescale 1ns/100ps
`include "tdct_map.svh"

module tdct_timers (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic [2:0] timer_irq,
  output logic [2:0] tone_out,
  output logic irq
);

  // ==========================================================================
  // Reset release
  logic rst_meta_q;
  logic rst_n;

  // Asynchronous assert, synchronous release
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  // ==========================================================================
  // Bus address phase capture
  tdct_pkg::tdct_ahb_req_t req;
  logic wr_q, wr_d, rd_q, rd_d;
  logic [7:0] addr_q, addr_d;

  assign req = '{hsel, haddr, htrans, hwrite, hsize, hready};
  assign hreadyout = 1'b1; // Never stalls, so no wait logic needed
  assign hresp = 1'b0;

  // Latch a valid NONSEQ or SEQ transfer for the data phase
  always_comb
  begin
    wr_d = req.hsel && req.hready && req.htrans[1] && req.hwrite;
    rd_d = req.hsel && req.hready && req.htrans[1] && !req.hwrite;
    addr_d = (req.hsel && req.hready) ? req.haddr[7:0] : addr_q;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      addr_q <= 8'h00;
    end
    else
    begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      addr_q <= addr_d;
    end
  end

  // ==========================================================================
  // Shared registers: system control, interrupt status and interrupt mask
  logic [3:0] sysctl_q, sysctl_d;
  logic [2:0] mask_q, mask_d;
  logic [2:0] stat_q, stat_d;
  logic [2:0] uflow;

  // System control carries clock select and mode of the first two timers
  always_comb
  begin
    sysctl_d = sysctl_q;
    mask_d = mask_q;
    if (wr_q && addr_q == `TDCT_OFF_SYSCTL)
      sysctl_d = hwdata[3:0];
    if (wr_q && addr_q == `TDCT_OFF_IRQ_MASK)
      mask_d = hwdata[2:0];
  end

  // Sticky status; a read clears, but a new underflow wins that cycle
  always_comb
  begin
    stat_d = stat_q;
    if (rd_q && addr_q == `TDCT_OFF_IRQ_STAT)
      stat_d = 3'h0;
    stat_d = stat_d | uflow;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sysctl_q <= 4'h0;
      mask_q <= 3'h0;
      stat_q <= 3'h0;
    end
    else
    begin
      sysctl_q <= sysctl_d;
      mask_q <= mask_d;
      stat_q <= stat_d;
    end
  end

  assign irq = |(stat_q & mask_q);

  // ==========================================================================
  // Tick dividers: fast, slow and third-timer rates from ref_clk
  // Fast and third-timer rates run fast as divisors of 25 MHz round down (third 3 vs 3.39); slow divides exactly
  localparam logic [15:0] DIV_FAST = 16'(`TDCT_DIV_FAST);
  localparam logic [15:0] DIV_SLOW = 16'(`TDCT_DIV_SLOW);
  localparam logic [15:0] DIV_T3 = 16'(`TDCT_DIV_T3);
  logic [15:0] dfast_q, dfast_d, dslow_q, dslow_d, dt3_q, dt3_d;
  logic tick_fast, tick_slow, tick_t3;

  always_comb
  begin
    tick_fast = (dfast_q == DIV_FAST - 16'h0001);
    tick_slow = (dslow_q == DIV_SLOW - 16'h0001);
    tick_t3 = (dt3_q == DIV_T3 - 16'h0001);
    dfast_d = tick_fast ? 16'h0000 : dfast_q + 16'h0001;
    dslow_d = tick_slow ? 16'h0000 : dslow_q + 16'h0001;
    dt3_d = tick_t3 ? 16'h0000 : dt3_q + 16'h0001;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dfast_q <= 16'h0000;
      dslow_q <= 16'h0000;
      dt3_q <= 16'h0000;
    end
    else
    begin
      dfast_q <= dfast_d;
      dslow_q <= dslow_d;
      dt3_q <= dt3_d;
    end
  end

  // ==========================================================================
  // Timer channels
  logic [15:0] count_q [3];
  logic [15:0] load_q [3];
  logic [7:0] ctrl_q [3];
  logic [2:0] armed_q;
  logic [2:0] pend_q;
  logic [2:0] tone_q;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_tmr
      localparam logic [7:0] BASE = 8'(gi * `TDCT_TMR_STRIDE);
      localparam int SB = (gi < 2) ? 2 * gi : 0; // Keeps the unused third-timer select in range
      logic [15:0] count_d, load_d;
      logic [7:0] ctrl_d;
      logic armed_d, pend_d, tone_d, tick, periodic, enabled, acc;

      // Source select: first two choose fast or slow, third is fixed
      always_comb
      begin
        if (gi < 2)
        begin
          tick = sysctl_q[SB] ? tick_slow : tick_fast;
          periodic = sysctl_q[SB + 1];
          enabled = 1'b1;
        end
        else
        begin
          tick = tick_t3;
          periodic = ctrl_q[gi][`TDCT_CTRL_MODE];
          enabled = ctrl_q[gi][`TDCT_CTRL_ENABLE];
        end
      end

      // Count, load and underflow handling
      always_comb
      begin
        count_d = count_q[gi];
        load_d = load_q[gi];
        ctrl_d = ctrl_q[gi];
        armed_d = armed_q[gi];
        pend_d = pend_q[gi];
        tone_d = tone_q[gi];
        acc = 1'b0;
        uflow[gi] = 1'b0;
        if (wr_q && addr_q == BASE + `TDCT_OFF_CTRL)
          ctrl_d = hwdata[7:0];
        if (wr_q && addr_q == BASE + `TDCT_OFF_LOAD)
        begin
          load_d = hwdata[15:0];
          count_d = hwdata[15:0];
          armed_d = 1'b1;
        end
        else if (tick && armed_q[gi] && enabled)
        begin
          acc = 1'b1;
          if (count_q[gi] == 16'h0000)
          begin
            uflow[gi] = 1'b1;
            tone_d = ~tone_q[gi];
            count_d = periodic ? load_q[gi] : `TDCT_RST_WRAP;
          end
          else
            count_d = count_q[gi] - 16'h0001;
        end
        if (wr_q && addr_q == BASE + `TDCT_OFF_CLEAR)
          pend_d = 1'b0;
        if (uflow[gi])
          pend_d = 1'b1;
      end

      always_ff @(posedge ref_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          count_q[gi] <= `TDCT_RST_COUNT;
          load_q[gi] <= `TDCT_RST_COUNT;
          ctrl_q[gi] <= 8'h00;
          armed_q[gi] <= 1'b0;
          pend_q[gi] <= 1'b0;
          tone_q[gi] <= 1'b0;
        end
        else
        begin
          count_q[gi] <= count_d;
          load_q[gi] <= load_d;
          ctrl_q[gi] <= ctrl_d;
          armed_q[gi] <= armed_d;
          pend_q[gi] <= pend_d;
          tone_q[gi] <= tone_d;
        end
      end

      // Interrupt pending rises at the edge that ends the underflow cycle
      chk_uflow_pend: assert property (@(posedge ref_clk) disable iff (!rst_n)
        uflow[gi] |=> pend_q[gi])
        else $error("pending not set after underflow");
      chk_load_now: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (wr_q && addr_q == BASE + `TDCT_OFF_LOAD) |=> count_q[gi] == $past(hwdata[15:0]))
        else $error("count not loaded by data write");
      chk_wrap_ffff: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (uflow[gi] && !periodic) |=> count_q[gi] == 16'hFFFF)
        else $error("free-running underflow did not wrap");
      chk_reload_val: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (uflow[gi] && periodic) |=> count_q[gi] == $past(load_q[gi]))
        else $error("periodic underflow did not reload");
      chk_hold_idle: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!acc && !(wr_q && addr_q == BASE + `TDCT_OFF_LOAD)) |=> $stable(count_q[gi]))
        else $error("count moved without a tick");
      chk_clear_pend: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (wr_q && addr_q == BASE + `TDCT_OFF_CLEAR && !uflow[gi]) |=> !pend_q[gi])
        else $error("clear write left interrupt pending");
    end
  endgenerate

  assign timer_irq = pend_q;
  assign tone_out = tone_q;
  // Third timer holds its count until it is both enabled and written
  chk_t3_armed: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!(armed_q[2] && ctrl_q[2][`TDCT_CTRL_ENABLE]) && !wr_q) |=> $stable(count_q[2]))
    else $error("third timer counted while idle");

  // ==========================================================================
  // Read data, registered in the address phase for a zero-wait answer
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] tsel;

  always_comb
  begin
    rdata_d = 32'h0000_0000;
    tsel = 2'(haddr[6:5]);
    if (hsel && hready && htrans[1] && !hwrite)
    begin
      if (haddr[7:0] == `TDCT_OFF_SYSCTL)
        rdata_d = {28'h0, sysctl_q};
      else if (haddr[7:0] == `TDCT_OFF_IRQ_STAT)
        rdata_d = {29'h0, stat_d};
      else if (haddr[7:0] == `TDCT_OFF_IRQ_MASK)
        rdata_d = {29'h0, mask_q};
      else if (tsel != 2'h3)
        case (haddr[4:0])
          5'(`TDCT_OFF_LOAD): rdata_d = {16'h0, load_q[tsel]};
          5'(`TDCT_OFF_VALUE): rdata_d = {16'h0, count_q[tsel]};
          5'(`TDCT_OFF_CTRL): rdata_d = {24'h0, ctrl_q[tsel]};
          default: rdata_d = 32'h0000_0000;
        endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata_q <= 32'h0000_0000;
    else
      rdata_q <= rdata_d;
  end

  assign hrdata = rdata_q;
  // A status read empties the sticky bits unless an underflow lands then
  chk_status_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (rd_q && addr_q == `TDCT_OFF_IRQ_STAT && uflow == 3'h0) |=> stat_q == 3'h0)
    else $error("status read did not clear");
endmodule

// ### testbench/tb_top.sv
// Purpose: self-checking bench for the three down-counting timers
// Assumes: zero-wait AHB-Lite slave, timer n at n*0x20, status bit n per timer
// Notes: timing windows allow for the free-running tick phase at load time
`timescale 1ns/100ps
`include "tdct_map.svh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("[ERR] %0t got %h want %h", $time, a, b); end end

module tb_top;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic irq;
  logic [2:0] timer_irq;
  logic [2:0] tone_out;
  logic [5:0] obs;
  int error_cnt = 0;
  int num_checks = 0;
  int n;
  integer seed = 98;
  logic [31:0] rd;
  logic [15:0] ld;
  logic tn;

  assign obs = {tone_out, timer_irq};

  tdct_timers DUT (.ref_clk(ref_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .timer_irq(timer_irq), .tone_out(tone_out), .irq(irq));

  // ==========================================================================
  // Clock, 40 ns period
  initial
  begin
    forever #20 ref_clk = ~ref_clk;
  end

  task print_verdict();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Bounded wait for the slave to be ready; the bus answer is taken at this edge
  task wait_rdy();
    int k;
    k = 0;
    do
    begin
      @(posedge ref_clk);
      k++;
      if (k > 50)
      begin
        error_cnt++;
        $display("[ERR] %0t bus hang", $time);
        print_verdict();
      end
    end while (hreadyout !== 1'b1);
  endtask

  // One single-word transfer: address phase held until ready, then data phase
  task xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
            output logic [31:0] r);
    @(posedge ref_clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    if (w)
      hwdata <= d;
    wait_rdy();
    r = hrdata;
  endtask

  // Wait for obs[k] to reach lvl; cnt counts settled cycles
  task wait_ev(input int k, input int lim, input logic lvl, output int cnt);
    cnt = 0;
    while (obs[k] !== lvl)
    begin
      @(posedge ref_clk);
      #1;
      cnt++;
      if (cnt > lim)
      begin
        error_cnt++;
        $display("[ERR] %0t event %0d missing", $time, k);
        print_verdict();
      end
    end
  endtask

  task idle(input int c);
    repeat (c) @(posedge ref_clk);
    #1;
  endtask

  // Underflow comes after ld+1 ticks; first tick phase is unknown
  function automatic logic in_win(input int cnt, input int l, input int dv);
    return (cnt >= l * dv - 2) && (cnt <= (l + 1) * dv + 3);
  endfunction

  function automatic logic near(input logic [15:0] v, input logic [15:0] e);
    return (v === e) || (v === e - 16'h1);
  endfunction

  // ==========================================================================
  // Main sequence
  initial
  begin
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    idle(3);
    // Quiet outputs after reset
    `CHK({irq, timer_irq, tone_out, hresp}, 8'h00)
    xfer(1'b0, 32'h7C, 32'h0, rd);
    `CHK(rd, 32'h0)
    xfer(1'b1, `TDCT_OFF_SYSCTL, 32'h0, rd);
    // Random loads read back at once, at most one tick later
    repeat (4)
    begin
      ld = 16'($random(seed)) | 16'h8;
      xfer(1'b1, `TDCT_OFF_LOAD, {16'($random(seed)), ld}, rd);
      xfer(1'b0, `TDCT_OFF_VALUE, 32'h0, rd);
      `CHK(near(rd[15:0], ld), 1'b1)
      xfer(1'b0, `TDCT_OFF_LOAD, 32'h0, rd);
      `CHK(rd, {16'h0, ld})
    end
    // First timer, fast source, free-running wrap
    xfer(1'b1, `TDCT_OFF_LOAD, 32'h3, rd);
    wait_ev(0, 400, 1'b1, n);
    `CHK(in_win(n, 3, `TDCT_DIV_FAST), 1'b1)
    xfer(1'b0, `TDCT_OFF_VALUE, 32'h0, rd);
    `CHK(rd[15:8], 8'hFF)
    `CHK(irq, 1'b0)
    xfer(1'b1, `TDCT_OFF_CLEAR, 32'h5A, rd);
    idle(2);
    `CHK(timer_irq[0], 1'b0)
    // Second timer, slow source chosen in system control
    xfer(1'b1, `TDCT_OFF_SYSCTL, 32'h4, rd);
    xfer(1'b1, `TDCT_TMR_STRIDE + `TDCT_OFF_LOAD, 32'h1, rd);
    wait_ev(1, 30000, 1'b1, n);
    `CHK(in_win(n, 1, `TDCT_DIV_SLOW), 1'b1)
    // Third timer waits for enable, then counts from its fixed source
    xfer(1'b1, 8'h40 + `TDCT_OFF_CTRL, 32'h0, rd);
    xfer(1'b1, 8'h40 + `TDCT_OFF_LOAD, 32'h2, rd);
    idle(20);
    xfer(1'b0, 8'h40 + `TDCT_OFF_VALUE, 32'h0, rd);
    `CHK(rd[15:0], 16'h2)
    xfer(1'b1, `TDCT_OFF_IRQ_MASK, 32'h4, rd);
    xfer(1'b1, 8'h40 + `TDCT_OFF_CTRL, 32'h80, rd);
    wait_ev(2, 60, 1'b1, n);
    `CHK(in_win(n, 2, `TDCT_DIV_T3), 1'b1)
    idle(2);
    `CHK(irq, 1'b1)
    xfer(1'b0, `TDCT_OFF_IRQ_STAT, 32'h0, rd);
    `CHK(rd[2], 1'b1)
    idle(3);
    `CHK(irq, 1'b0)
    xfer(1'b0, `TDCT_OFF_IRQ_STAT, 32'h0, rd);
    `CHK(rd[2], 1'b0)
    // Third timer periodic: exact reload period on the tone output
    ld = 16'(4 + ($random(seed) & 31));
    xfer(1'b1, 8'h40 + `TDCT_OFF_CTRL, 32'hC0, rd);
    xfer(1'b1, 8'h40 + `TDCT_OFF_LOAD, {16'h0, ld}, rd);
    tn = tone_out[2];
    wait_ev(5, 400, ~tn, n);
    wait_ev(5, 400, tn, n);
    `CHK(n, (ld + 1) * `TDCT_DIV_T3)
    xfer(1'b0, 8'h40 + `TDCT_OFF_VALUE, 32'h0, rd);
    `CHK(rd[15:0] <= ld, 1'b1)
    // First timer periodic through its system control mode bit
    xfer(1'b1, `TDCT_OFF_SYSCTL, 32'hA, rd);
    xfer(1'b1, `TDCT_OFF_LOAD, 32'h1, rd);
    tn = tone_out[0];
    wait_ev(3, 400, ~tn, n);
    wait_ev(3, 400, tn, n);
    `CHK(n, 2 * `TDCT_DIV_FAST)
    // Second timer periodic through its system control mode bit, fast source
    xfer(1'b1, `TDCT_TMR_STRIDE + `TDCT_OFF_LOAD, 32'h1, rd);
    tn = tone_out[1];
    wait_ev(4, 400, ~tn, n);
    wait_ev(4, 400, tn, n);
    `CHK(n, 2 * `TDCT_DIV_FAST)
    print_verdict();
  end
endmodule
